// >>> dlc_compositor.sv
/*
 Display layer compositor: APB register file, raster timing, double-buffer
 flips, display fetch addressing, graphics memory arbiter and layer mixing.
 Assumes fetched layer and cursor pixels arrive on SYS_CLK aligned with the
 current raster position, one pixel per clock.
*/
`timescale 1ns/1ps
`default_nettype none
module dlc_compositor (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    input wire logic [15:0] CON_PIX,
    input wire logic [15:0] WIN_PIX,
    input wire logic [15:0] MID_PIX,
    input wire logic [15:0] BASE_PIX,
    input wire logic [7:0] CUR0_PIX,
    input wire logic [7:0] CUR1_PIX,
    input wire logic [1:0] CUR_HIT,
    input wire logic REFRESH_REQ,
    input wire logic CAPTURE_REQ,
    input wire logic HOST_REQ,
    input wire logic DRAW_REQ,
    output logic [4:0] MEM_GNT,
    output logic [31:0] DISP_ADDR,
    output logic [2:0] DISP_FIELD,
    output logic HSYNC_N,
    output logic VSYNC_N,
    output logic DISP_DE,
    output logic [17:0] PIX_RGB
);
    dlc_pkg::dlc_cfg_t cfg_r, cfg_nxt;
    logic [11:0] tim_r [dlc_pkg::N_TIM];
    logic [11:0] tim_nxt [dlc_pkg::N_TIM];
    logic [15:0] trans_r [dlc_pkg::N_TRANS];
    logic [15:0] trans_nxt [dlc_pkg::N_TRANS];
    logic [31:0] org_r [dlc_pkg::N_FIELDS];
    logic [31:0] org_nxt [dlc_pkg::N_FIELDS];
    logic [31:0] alt_r [dlc_pkg::N_FIELDS];
    logic [31:0] alt_nxt [dlc_pkg::N_FIELDS];
    dlc_pkg::dlc_geom_t geom_r [dlc_pkg::N_FIELDS];
    dlc_pkg::dlc_geom_t geom_nxt [dlc_pkg::N_FIELDS];
    dlc_pkg::dlc_pos_t pos_r [dlc_pkg::N_FIELDS];
    dlc_pkg::dlc_pos_t pos_nxt [dlc_pkg::N_FIELDS];
    logic [18:0] clut_con [256];
    logic [17:0] clut_mb [256];
    logic [3:0] dbl_en_r, dbl_en_nxt, flip_req_r, flip_req_nxt, shown_alt_r, shown_alt_nxt;
    logic pready_nxt, pslverr_nxt;
    logic [31:0] prdata_nxt;
    logic [11:0] hcnt_r, hcnt_nxt, vcnt_r, vcnt_nxt;
    logic [2:0] fsel_r, fsel_nxt;
    logic [31:0] daddr_nxt;
    logic [4:0] gnt_nxt;
    logic hs_nxt, vs_nxt, de_nxt;
    dlc_pkg::dlc_rgb_t rgb_nxt;
    logic wr, hit, flip_now, h_act, v_act, dreq;
    logic [7:0] idx;
    logic [2:0] fi;
    logic [1:0] fw;

    assign wr = PSEL & PENABLE & PWRITE & PREADY;
    assign idx = PADDR[9:2];
    assign fi = PADDR[6:4];
    assign fw = PADDR[3:2];
    assign h_act = hcnt_r < tim_r[dlc_pkg::T_HACTIVE];
    assign v_act = vcnt_r < tim_r[dlc_pkg::T_VACTIVE];
    // Flip point is the first pixel of vertical blanking
    assign flip_now = (vcnt_r == tim_r[dlc_pkg::T_VACTIVE]) && (hcnt_r == 12'h000);

    function automatic dlc_pkg::dlc_rgb_t direct_rgb(input logic [15:0] p);
        direct_rgb = '{r: {p[14:10], p[14]}, g: {p[9:5], p[9]}, b: {p[4:0], p[4]}};
    endfunction

    function automatic logic [5:0] mix_c(input logic [5:0] a, input logic [5:0] b,
                                         input logic [3:0] k, input logic swap);
        logic [4:0] kk;
        logic [4:0] ki;
        logic [11:0] s;
        kk = {1'b0, k};
        ki = dlc_pkg::BLEND_ONE - kk;
        if (swap) begin
            s = 12'(a) * 12'(ki) + 12'(b) * 12'(kk);
        end else begin
            s = 12'(a) * 12'(kk) + 12'(b) * 12'(ki);
        end
        mix_c = s[9:4];
    endfunction

    function automatic dlc_pkg::dlc_rgb_t mix(input dlc_pkg::dlc_rgb_t a, input dlc_pkg::dlc_rgb_t b,
                                              input logic [3:0] k, input logic swap);
        mix = '{r: mix_c(a.r, b.r, k, swap), g: mix_c(a.g, b.g, k, swap), b: mix_c(a.b, b.b, k, swap)};
    endfunction

    // Register file writes
    always_comb begin
        cfg_nxt = cfg_r;
        tim_nxt = tim_r;
        trans_nxt = trans_r;
        org_nxt = org_r;
        alt_nxt = alt_r;
        geom_nxt = geom_r;
        pos_nxt = pos_r;
        dbl_en_nxt = dbl_en_r;
        if (wr) begin
            if (PADDR == dlc_pkg::OFF_CTRL) begin
                cfg_nxt = dlc_pkg::dlc_cfg_t'(PWDATA[dlc_pkg::CFG_W-1:0]);
            end
            for (int i = 0; i < dlc_pkg::N_TIM; i++) begin
                if (PADDR == dlc_pkg::OFF_TIM + 12'(4 * i)) begin
                    tim_nxt[i] = PWDATA[11:0];
                end
            end
            for (int i = 0; i < dlc_pkg::N_TRANS; i++) begin
                if (PADDR == dlc_pkg::OFF_TRANS + 12'(4 * i)) begin
                    trans_nxt[i] = PWDATA[15:0];
                end
            end
            if (PADDR == dlc_pkg::OFF_DBUF) begin
                dbl_en_nxt = PWDATA[3:0];
            end
            if (PADDR[11:7] == dlc_pkg::OFF_FIELD[11:7] && fi < 3'(dlc_pkg::N_FIELDS)) begin
                unique case (fw)
                    dlc_pkg::FW_ORG: org_nxt[fi] = PWDATA;
                    dlc_pkg::FW_ALT: alt_nxt[fi] = PWDATA;
                    dlc_pkg::FW_GEOM: geom_nxt[fi] = dlc_pkg::dlc_geom_t'(PWDATA[16:0]);
                    dlc_pkg::FW_POS: pos_nxt[fi] = '{dy: PWDATA[27:16], dx: PWDATA[11:0]};
                endcase
            end
        end
    end

    // Flip requests: a software set in the flip cycle survives the clear
    always_comb begin
        flip_req_nxt = flip_req_r;
        shown_alt_nxt = shown_alt_r;
        if (flip_now) begin
            for (int i = 0; i < 4; i++) begin
                if (dbl_en_r[i] && (cfg_r.flip_auto || flip_req_r[i])) begin
                    shown_alt_nxt[i] = ~shown_alt_r[i];
                end
            end
            flip_req_nxt = 4'h0;
        end
        if (wr && PADDR == dlc_pkg::OFF_DBUF) begin
            flip_req_nxt = flip_req_nxt | PWDATA[7:4];
        end
    end

    // APB answer one wait state after the access phase opens
    always_comb begin
        pready_nxt = PSEL & PENABLE & ~PREADY;
        prdata_nxt = 32'h0000_0000;
        hit = 1'b0;
        if (PADDR == dlc_pkg::OFF_CTRL) begin
            hit = 1'b1;
            prdata_nxt = 32'(cfg_r);
        end
        for (int i = 0; i < dlc_pkg::N_TIM; i++) begin
            if (PADDR == dlc_pkg::OFF_TIM + 12'(4 * i)) begin
                hit = 1'b1;
                prdata_nxt = {20'h00000, tim_r[i]};
            end
        end
        for (int i = 0; i < dlc_pkg::N_TRANS; i++) begin
            if (PADDR == dlc_pkg::OFF_TRANS + 12'(4 * i)) begin
                hit = 1'b1;
                prdata_nxt = {16'h0000, trans_r[i]};
            end
        end
        if (PADDR == dlc_pkg::OFF_DBUF) begin
            hit = 1'b1;
            prdata_nxt = {20'h00000, shown_alt_r, flip_req_r, dbl_en_r};
        end
        if (PADDR == dlc_pkg::OFF_STATUS) begin
            hit = 1'b1;
            prdata_nxt = {2'h0, ~v_act, ~h_act, hcnt_r, 4'h0, vcnt_r};
        end
        if (PADDR[11:7] == dlc_pkg::OFF_FIELD[11:7] && fi < 3'(dlc_pkg::N_FIELDS)) begin
            hit = 1'b1;
            unique case (fw)
                dlc_pkg::FW_ORG: prdata_nxt = org_r[fi];
                dlc_pkg::FW_ALT: prdata_nxt = alt_r[fi];
                dlc_pkg::FW_GEOM: prdata_nxt = {15'h0000, geom_r[fi]};
                dlc_pkg::FW_POS: prdata_nxt = {4'h0, pos_r[fi].dy, 4'h0, pos_r[fi].dx};
            endcase
        end
        if (PADDR[11:10] == dlc_pkg::OFF_CLUT_CON[11:10]) begin
            hit = 1'b1;
            prdata_nxt = {13'h0000, clut_con[idx]};
        end
        if (PADDR[11:10] == dlc_pkg::OFF_CLUT_MB[11:10]) begin
            hit = 1'b1;
            prdata_nxt = {14'h0000, clut_mb[idx]};
        end
        if (!pready_nxt) begin
            prdata_nxt = 32'h0000_0000;
        end
        pslverr_nxt = pready_nxt & ~hit;
    end

    // Raster timing
    always_comb begin
        hcnt_nxt = hcnt_r + 12'h001;
        vcnt_nxt = vcnt_r;
        if (hcnt_r >= tim_r[dlc_pkg::T_HTOTAL] - 12'h001) begin
            hcnt_nxt = 12'h000;
            vcnt_nxt = (vcnt_r >= tim_r[dlc_pkg::T_VTOTAL] - 12'h001) ? 12'h000 : vcnt_r + 12'h001;
        end
        if (!cfg_r.disp_en) begin
            hcnt_nxt = 12'h000;
            vcnt_nxt = 12'h000;
        end
        hs_nxt = ~(hcnt_r >= tim_r[dlc_pkg::T_HSSTART] &&
            hcnt_r <= tim_r[dlc_pkg::T_HSSTART] + tim_r[dlc_pkg::T_HSWIDTH]);
        vs_nxt = ~(vcnt_r >= tim_r[dlc_pkg::T_VSSTART] &&
            vcnt_r <= tim_r[dlc_pkg::T_VSSTART] + tim_r[dlc_pkg::T_VSWIDTH]);
        de_nxt = cfg_r.disp_en & h_act & v_act;
    end

    // Display fetch address for the field being fetched
    always_comb begin
        logic left;
        logic [2:0] f;
        logic [31:0] org;
        logic [13:0] wpix, hpix, xs, ys;
        dlc_pkg::dlc_geom_t g;
        left = hcnt_r < tim_r[dlc_pkg::T_HSPLIT];
        f = fsel_r;
        if ((f == dlc_pkg::FLD_MR || f == dlc_pkg::FLD_BR) && left) begin
            f = f - 3'h1;
        end
        g = geom_r[f];
        org = org_r[f];
        if (f >= dlc_pkg::FLD_ML && dbl_en_r[2'(f - dlc_pkg::FLD_ML)] && shown_alt_r[2'(f - dlc_pkg::FLD_ML)]) begin
            org = alt_r[f];
        end
        // 32-pixel frame steps (64 pixels wide at 8 bpp), at most 4096 each way
        wpix = {6'h00, g.width_units} << (g.bpp16 ? dlc_pkg::FRAME_UNIT_SH : dlc_pkg::FRAME_UNIT_SH + 1);
        hpix = {6'h00, g.height_units} << dlc_pkg::FRAME_UNIT_SH;
        if (wpix > dlc_pkg::FRAME_MAX) begin
            wpix = dlc_pkg::FRAME_MAX;
        end
        if (hpix > dlc_pkg::FRAME_MAX) begin
            hpix = dlc_pkg::FRAME_MAX;
        end
        xs = {2'h0, hcnt_r} + {2'h0, pos_r[f].dx};
        ys = {2'h0, vcnt_r} + {2'h0, pos_r[f].dy};
        if (xs >= wpix) begin
            xs = xs - wpix;
        end
        if (ys >= hpix) begin
            ys = ys - hpix;
        end
        daddr_nxt = org + (g.bpp16 ? 32'({xs, 1'b0}) : 32'(xs)) +
            (32'(g.width_units) * 32'(ys) << dlc_pkg::ROW_BYTES_SH);
        fsel_nxt = fsel_r;
        if (MEM_GNT[1]) begin
            fsel_nxt = (fsel_r == dlc_pkg::FLD_BR) ? dlc_pkg::FLD_CON : fsel_r + 3'h1;
        end
    end

    // Fixed-priority arbiter, one grant per cycle
    assign dreq = cfg_r.disp_en & v_act & h_act;
    always_comb begin
        if (REFRESH_REQ) begin
            gnt_nxt = 5'h01;
        end else if (dreq) begin
            gnt_nxt = 5'h02;
        end else if (CAPTURE_REQ) begin
            gnt_nxt = 5'h04;
        end else if (HOST_REQ) begin
            gnt_nxt = 5'h08;
        end else if (DRAW_REQ) begin
            gnt_nxt = 5'h10;
        end else begin
            gnt_nxt = 5'h00;
        end
    end

    // Layer composition, top to bottom
    always_comb begin
        logic left, con_op, con_alpha, mid_op, win_on, c0_op, c1_op, cur_up, cur_dn;
        logic [15:0] mcode;
        dlc_pkg::dlc_rgb_t con_c, mid_c, base_c, low_c, cur_up_c, cur_dn_c;
        left = hcnt_r < tim_r[dlc_pkg::T_HSPLIT];
        if (cfg_r.con_indirect) begin
            con_c = clut_con[CON_PIX[7:0]][17:0];
            con_alpha = clut_con[CON_PIX[7:0]][18];
            con_op = CON_PIX[7:0] != trans_r[dlc_pkg::TR_CON][7:0];
        end else begin
            con_c = direct_rgb(CON_PIX);
            con_alpha = CON_PIX[15];
            con_op = CON_PIX[14:0] != trans_r[dlc_pkg::TR_CON][14:0];
        end
        mcode = left ? trans_r[dlc_pkg::TR_ML] : trans_r[dlc_pkg::TR_MR];
        mid_c = cfg_r.mid_indirect ? clut_mb[MID_PIX[7:0]] : direct_rgb({1'b0, MID_PIX[14:0]});
        mid_op = cfg_r.mid_indirect ? (MID_PIX[7:0] != mcode[7:0]) : (MID_PIX[14:0] != mcode[14:0]);
        base_c = cfg_r.base_indirect ? clut_mb[BASE_PIX[7:0]] : direct_rgb({1'b0, BASE_PIX[14:0]});
        win_on = hcnt_r >= tim_r[dlc_pkg::T_WLEFT] &&
            hcnt_r < tim_r[dlc_pkg::T_WLEFT] + tim_r[dlc_pkg::T_WSPAN] &&
            vcnt_r >= tim_r[dlc_pkg::T_WTOP] && vcnt_r < tim_r[dlc_pkg::T_WTOP] + tim_r[dlc_pkg::T_WROWS];
        if (win_on) begin
            // Video words carry luminance in the upper byte; shown as grey
            if (cfg_r.win_video) begin
                low_c = '{r: WIN_PIX[15:10], g: WIN_PIX[15:10], b: WIN_PIX[15:10]};
            end else begin
                low_c = direct_rgb({1'b0, WIN_PIX[14:0]});
            end
        end else if (mid_op) begin
            low_c = mid_c;
        end else begin
            low_c = base_c;
        end
        // Code 0 and the cursor code are see-through; cursor 1 beats cursor 0 when both are on the same side of the console
        c0_op = CUR_HIT[0] && CUR0_PIX != 8'h00 && CUR0_PIX != trans_r[dlc_pkg::TR_CUR][7:0];
        c1_op = CUR_HIT[1] && CUR1_PIX != 8'h00 && CUR1_PIX != trans_r[dlc_pkg::TR_CUR][7:0];
        cur_up = (c1_op && cfg_r.cursor_over_con[1]) || (c0_op && cfg_r.cursor_over_con[0]);
        cur_up_c = (c1_op && cfg_r.cursor_over_con[1]) ? clut_con[CUR1_PIX][17:0] : clut_con[CUR0_PIX][17:0];
        cur_dn = (c1_op && !cfg_r.cursor_over_con[1]) || (c0_op && !cfg_r.cursor_over_con[0]);
        cur_dn_c = (c1_op && !cfg_r.cursor_over_con[1]) ? clut_con[CUR1_PIX][17:0] : clut_con[CUR0_PIX][17:0];
        if (cur_up) begin
            rgb_nxt = (cfg_r.blend_en && con_op && con_alpha) ?
                mix(con_c, cur_up_c, cfg_r.blend_ratio_setting, cfg_r.coefficient_swap) : cur_up_c;
        end else if (con_op) begin
            rgb_nxt = (cfg_r.blend_en && con_alpha) ?
                mix(con_c, cur_dn ? cur_dn_c : low_c, cfg_r.blend_ratio_setting, cfg_r.coefficient_swap) : con_c;
        end else if (cur_dn) begin
            rgb_nxt = cur_dn_c;
        end else begin
            rgb_nxt = low_c;
        end
        if (!de_nxt) begin
            rgb_nxt = '0;
        end
    end

    // Colour tables are memories written straight from the bus
    always_ff @(posedge SYS_CLK) begin
        if (wr && PADDR[11:10] == dlc_pkg::OFF_CLUT_CON[11:10]) begin
            clut_con[idx] <= PWDATA[18:0];
        end
        if (wr && PADDR[11:10] == dlc_pkg::OFF_CLUT_MB[11:10]) begin
            clut_mb[idx] <= PWDATA[17:0];
        end
    end

    always_ff @(posedge SYS_CLK) begin
        if (!RESETN) begin
            cfg_r <= '0;
            tim_r <= dlc_pkg::TIM_RST;
            trans_r <= '{default: dlc_pkg::TRANS_RST};
            org_r <= '{default: dlc_pkg::ORG_RST};
            alt_r <= '{default: dlc_pkg::ORG_RST};
            geom_r <= '{default: '{bpp16: 1'b1, height_units: dlc_pkg::UNITS_RST, width_units: dlc_pkg::UNITS_RST}};
            pos_r <= '{default: '0};
            dbl_en_r <= 4'h0;
            flip_req_r <= 4'h0;
            shown_alt_r <= 4'h0;
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
            hcnt_r <= 12'h000;
            vcnt_r <= 12'h000;
            fsel_r <= dlc_pkg::FLD_CON;
            MEM_GNT <= 5'h00;
            DISP_ADDR <= 32'h0000_0000;
            DISP_FIELD <= dlc_pkg::FLD_CON;
            HSYNC_N <= 1'b1;
            VSYNC_N <= 1'b1;
            DISP_DE <= 1'b0;
            PIX_RGB <= 18'h00000;
        end else begin
            cfg_r <= cfg_nxt;
            tim_r <= tim_nxt;
            trans_r <= trans_nxt;
            org_r <= org_nxt;
            alt_r <= alt_nxt;
            geom_r <= geom_nxt;
            pos_r <= pos_nxt;
            dbl_en_r <= dbl_en_nxt;
            flip_req_r <= flip_req_nxt;
            shown_alt_r <= shown_alt_nxt;
            PREADY <= pready_nxt;
            PRDATA <= prdata_nxt;
            PSLVERR <= pslverr_nxt;
            hcnt_r <= hcnt_nxt;
            vcnt_r <= vcnt_nxt;
            fsel_r <= fsel_nxt;
            MEM_GNT <= gnt_nxt;
            DISP_ADDR <= daddr_nxt;
            DISP_FIELD <= fsel_r;
            HSYNC_N <= hs_nxt;
            VSYNC_N <= vs_nxt;
            DISP_DE <= de_nxt;
            PIX_RGB <= rgb_nxt;
        end
    end
endmodule
`default_nettype wire

// >>> dlc_pkg.sv
/*
 Shared constants and types of the display layer compositor: APB register
 offsets, reset values, layer field indices and the packed carrier types.
 Assumes a 32-bit APB with a 12-bit byte address.
*/
`default_nettype none
package dlc_pkg;
    localparam int unsigned N_FIELDS = 6;
    localparam int unsigned N_TIM = 13;
    localparam int unsigned N_TRANS = 4;
    localparam int unsigned CFG_W = 14;

    // Field indices
    localparam logic [2:0] FLD_CON = 3'h0;
    localparam logic [2:0] FLD_WIN = 3'h1;
    localparam logic [2:0] FLD_ML = 3'h2;
    localparam logic [2:0] FLD_MR = 3'h3;
    localparam logic [2:0] FLD_BL = 3'h4;
    localparam logic [2:0] FLD_BR = 3'h5;

    // Timing and window parameter indices
    localparam int unsigned T_HTOTAL = 0;
    localparam int unsigned T_HACTIVE = 1;
    localparam int unsigned T_HSSTART = 2;
    localparam int unsigned T_HSWIDTH = 3;
    localparam int unsigned T_HSPLIT = 4;
    localparam int unsigned T_VTOTAL = 5;
    localparam int unsigned T_VACTIVE = 6;
    localparam int unsigned T_VSSTART = 7;
    localparam int unsigned T_VSWIDTH = 8;
    localparam int unsigned T_WLEFT = 9;
    localparam int unsigned T_WTOP = 10;
    localparam int unsigned T_WSPAN = 11;
    localparam int unsigned T_WROWS = 12;

    // Transparent code indices
    localparam int unsigned TR_CON = 0;
    localparam int unsigned TR_ML = 1;
    localparam int unsigned TR_MR = 2;
    localparam int unsigned TR_CUR = 3;

    // Register byte offsets
    localparam logic [11:0] OFF_CTRL = 12'h000;
    localparam logic [11:0] OFF_TIM = 12'h004;
    localparam logic [11:0] OFF_TRANS = 12'h038;
    localparam logic [11:0] OFF_DBUF = 12'h048;
    localparam logic [11:0] OFF_STATUS = 12'h04c;
    localparam logic [11:0] OFF_FIELD = 12'h080;
    localparam logic [11:0] OFF_CLUT_CON = 12'h400;
    localparam logic [11:0] OFF_CLUT_MB = 12'h800;

    // Field register word within a field's 16-byte slot
    localparam logic [1:0] FW_ORG = 2'h0;
    localparam logic [1:0] FW_ALT = 2'h1;
    localparam logic [1:0] FW_GEOM = 2'h2;
    localparam logic [1:0] FW_POS = 2'h3;

    // Frame granularity and limits
    localparam int unsigned FRAME_UNIT_SH = 5;
    localparam logic [13:0] FRAME_MAX = 14'h1000;
    localparam int unsigned ROW_BYTES_SH = 6;
    localparam logic [4:0] BLEND_ONE = 5'h10;

    // Reset values: 640 x 480 raster, window off
    localparam logic [11:0] TIM_RST [N_TIM] = '{12'h320, 12'h280, 12'h290, 12'h05f, 12'h280,
        12'h20d, 12'h1e0, 12'h1ea, 12'h001, 12'h000, 12'h000, 12'h000, 12'h000};
    localparam logic [15:0] TRANS_RST = 16'h0000;
    localparam logic [31:0] ORG_RST = 32'h0000_0000;
    localparam logic [7:0] UNITS_RST = 8'h01;

    typedef struct packed {
        logic win_video;
        logic base_indirect;
        logic mid_indirect;
        logic con_indirect;
        logic flip_auto;
        logic [1:0] cursor_over_con;
        logic [3:0] blend_ratio_setting;
        logic coefficient_swap;
        logic blend_en;
        logic disp_en;
    } dlc_cfg_t;

    typedef struct packed {
        logic bpp16;
        logic [7:0] height_units;
        logic [7:0] width_units;
    } dlc_geom_t;

    typedef struct packed {
        logic [11:0] dy;
        logic [11:0] dx;
    } dlc_pos_t;

    typedef struct packed {
        logic [5:0] r;
        logic [5:0] g;
        logic [5:0] b;
    } dlc_rgb_t;
endpackage
`default_nettype wire

// >>> dlc_compositor_sva.sv
/* Port checker for dlc_compositor: APB wait, grant order, raster outputs.
   Assumes the bench programs a 3-pixel horizontal sync width, a 1-line
   vertical sync width and 40-pixel lines. */
`timescale 1ns/1ps
`default_nettype none
module dlc_compositor_sva (
    input wire logic SYS_CLK,
    input wire logic RESETN,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PREADY,
    input wire logic REFRESH_REQ,
    input wire logic CAPTURE_REQ,
    input wire logic HOST_REQ,
    input wire logic [4:0] MEM_GNT,
    input wire logic HSYNC_N,
    input wire logic VSYNC_N,
    input wire logic DISP_DE,
    input wire logic [17:0] PIX_RGB
);
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RESETN);
    // Width 3 plus one, so four low pixels
    sequence s_hs_low;
        !HSYNC_N [*4] ##1 HSYNC_N;
    endsequence
    // Two lines of 40 pixels, so eighty low cycles
    sequence s_vs_low;
        ##79 !VSYNC_N ##1 VSYNC_N;
    endsequence
    a_apb_wait: assert property (PSEL && PENABLE && !PREADY |=> PREADY)
        else $error("apb answer not after one wait");
    a_gnt_onehot: assert property ($onehot0(MEM_GNT))
        else $error("grant not one-hot");
    a_refresh_first: assert property (REFRESH_REQ |=> MEM_GNT == 5'h01)
        else $error("refresh not granted first");
    a_capture_over: assert property (!REFRESH_REQ && CAPTURE_REQ |=> MEM_GNT[4:3] == 2'h0)
        else $error("host or draw beat capture");
    a_host_over: assert property (!REFRESH_REQ && HOST_REQ |=> !MEM_GNT[4])
        else $error("draw beat host");
    a_blank_dark: assert property (!DISP_DE |-> PIX_RGB == 18'h0)
        else $error("pixel not dark in blanking");
    a_hs_width: assert property ($fell(HSYNC_N) |-> s_hs_low)
        else $error("hsync pulse width wrong");
    a_de_quiet: assert property (DISP_DE |-> HSYNC_N && VSYNC_N)
        else $error("sync inside active area");
    a_disp_grant: assert property (DISP_DE && !$past(REFRESH_REQ) |-> MEM_GNT == 5'h02)
        else $error("display fetch not granted in active area");
    a_vs_width: assert property ($fell(VSYNC_N) |-> s_vs_low)
        else $error("vsync pulse width wrong");
endmodule
bind dlc_compositor dlc_compositor_sva dlc_compositor_sva_i (.SYS_CLK, .RESETN, .PSEL, .PENABLE, .PREADY,
    .REFRESH_REQ, .CAPTURE_REQ, .HOST_REQ, .MEM_GNT, .HSYNC_N, .VSYNC_N, .DISP_DE, .PIX_RGB);
`default_nettype wire

// >>> dlc_monitor.sv
/* Display monitor model: measures active pixels of each line.
   Assumes one pixel per clock while the data enable is high. */
`timescale 1ns/1ps
`default_nettype none
module dlc_monitor (
    input wire logic clk,
    input wire logic de,
    output logic [11:0] run_len,
    output logic line_stb
);
    logic [11:0] cnt_r = 12'h0;
    always_ff @(posedge clk) begin
        line_stb <= 1'b0;
        if (de) begin
            cnt_r <= cnt_r + 12'h1;
        end else if (cnt_r != 12'h0) begin
            run_len <= cnt_r;
            line_stb <= 1'b1;
            cnt_r <= 12'h0;
        end
    end
endmodule
`default_nettype wire

// >>> dlc_compositor_tb.sv
/* Bench for dlc_compositor: APB reads, small raster, layer priority.
   Assumes a 200 MHz SYS_CLK and random memory requests each cycle. */
`timescale 1ns/1ps
`default_nettype none
module dlc_compositor_tb;
    logic clk = 1'b0, rstn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, chk = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, addr;
    logic [15:0] con = 16'h0, mid = 16'h0, base = 16'h0, v [3];
    logic [3:0] req = 4'h0;
    logic pready, pslverr, hs_n, vs_n, de, stb;
    logic [4:0] gnt;
    logic [2:0] fld;
    logic [17:0] rgb, exp_rgb;
    logic [11:0] len;
    logic [11:0] ln = 12'h0;
    logic de_q = 1'b0;
    logic [2:0] ef;
    logic [32:0] q [$];
    logic [11:0] tim [13] = '{12'h028, 12'h010, 12'h014, 12'h003, 12'h010, 12'h01e, 12'h008, 12'h00a,
        12'h001, 12'h000, 12'h000, 12'h000, 12'h000};
    integer seed = 32'h78c1;
    int n_errors = 0, checked = 0, cyc = 0;
    always #2.5 clk = ~clk;
    dlc_compositor dlc_compositor_i (.SYS_CLK(clk), .RESETN(rstn), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
        .CON_PIX(con), .WIN_PIX(16'h0), .MID_PIX(mid), .BASE_PIX(base), .CUR0_PIX(8'h0), .CUR1_PIX(8'h0),
        .CUR_HIT(2'h0), .REFRESH_REQ(req[0]), .CAPTURE_REQ(req[1]), .HOST_REQ(req[2]), .DRAW_REQ(req[3]),
        .MEM_GNT(gnt), .DISP_ADDR(addr), .DISP_FIELD(fld), .HSYNC_N(hs_n), .VSYNC_N(vs_n), .DISP_DE(de),
        .PIX_RGB(rgb));
    dlc_monitor dlc_monitor_i (.clk(clk), .de(de), .run_len(len), .line_stb(stb));
    task automatic wrap_up();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [32:0] e, input logic [32:0] s);
        checked++;
        if (s !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask
    // Expanded by repeating each colour MSB
    function automatic logic [17:0] ex(input logic [15:0] p);
        return {p[14:10], p[14], p[9:5], p[9], p[4:0], p[4]};
    endfunction
    always @(posedge clk) begin
        req <= 4'($random(seed));
        cyc++;
        de_q <= de;
        // Line index of the fetch, restarted by vertical sync
        if (!vs_n)
            ln <= 12'h0;
        else if (de && !de_q)
            ln <= ln + 12'h1;
        ef = fld - {2'h0, fld == 3'h3 || fld == 3'h5};
        if (de && !de_q && chk)
            cmp("fetch addr", {1'b0, (32'(ef) << 20) + (32'(ln) << 6)}, {1'b0, addr});
        if (psel && penable && !pwrite && pready === 1'b1 && q.size() > 0)
            cmp("apb read", q.pop_front(), {pslverr, prdata});
        if (stb && chk)
            cmp("line width", 33'h10, {21'h0, len});
        if (de && chk)
            cmp("pixel", {15'h0, exp_rgb}, {15'h0, rgb});
        if (cyc == 10000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 13; i++)
            rd(dlc_pkg::OFF_TIM + 12'(4 * i), {21'h0, dlc_pkg::TIM_RST[i]});
        rd(12'h050, 33'h1_0000_0000);
        for (int i = 0; i < 13; i++)
            apb(1'b1, dlc_pkg::OFF_TIM + 12'(4 * i), {20'h0, tim[i]});
        // Distinct origin per field; right fields double buffered, all requesting a flip
        for (int f = 0; f < 6; f++)
            apb(1'b1, dlc_pkg::OFF_FIELD + 12'(16 * f), 32'(f) << 20);
        apb(1'b1, dlc_pkg::OFF_DBUF, 32'h0000_00fa);
        rd(dlc_pkg::OFF_DBUF, 33'h0fa);
        apb(1'b1, dlc_pkg::OFF_CTRL, 32'h1);
        rd(dlc_pkg::OFF_CTRL, 33'h1);
        // Console, then middle, then base wins
        for (int k = 0; k < 3; k++) begin
            foreach (v[j])
                v[j] = {1'b0, 15'($random(seed))} | 16'h0001;
            chk <= 1'b0;
            con <= (k == 0) ? v[0] : 16'h0;
            mid <= (k < 2) ? v[1] : 16'h0;
            base <= v[2];
            exp_rgb <= ex(v[k]);
            repeat (50) @(posedge clk);
            chk <= 1'b1;
            repeat (1300) @(posedge clk);
        end
        rd(dlc_pkg::OFF_DBUF, 33'ha0a);
        wrap_up();
    end
endmodule
`default_nettype wire
